// File: src/cms_pkg.sv
// Constants, layouts and carrier types for the core mode and special registers
package cms_pkg;
    localparam int XLEN = 32;
    localparam int NGPR = 13;
    localparam int ADDR_W = 6;
    localparam int PRIO_W = 9;

    // Register bus byte offsets, one aligned word each
    localparam logic [ADDR_W-1:0] OFF_PSR = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_APPLICATION_STATUS_VIEW = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_INTERRUPT_STATUS_VIEW = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_EXECUTION_STATUS_VIEW = 6'h0c;
    localparam logic [ADDR_W-1:0] OFF_PRIMARY_INTERRUPT_MASK = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_FAULT_LEVEL_MASK = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_PRIORITY_THRESHOLD_MASK = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_MODE = 6'h1c;
    localparam logic [ADDR_W-1:0] OFF_MSP = 6'h20;
    localparam logic [ADDR_W-1:0] OFF_PSP = 6'h24;
    localparam logic [ADDR_W-1:0] OFF_OPSTATE = 6'h28;

    // Status word field positions
    localparam int APPLICATION_STATUS_VIEW_LSB = 27;
    localparam int APPLICATION_STATUS_VIEW_MSB = 31;
    localparam int INTERRUPT_STATUS_VIEW_MSB = 8;
    localparam int ICI_LSB = 10;
    localparam int ICI_MSB = 15;
    localparam int TBIT_POS = 24;
    localparam int IT_LSB = 25;
    localparam int IT_MSB = 26;

    // Mode select bits
    localparam int MODE_USER_BIT = 0;
    localparam int MODE_STACK_BIT = 1;

    // Core register indices
    localparam logic [3:0] IDX_HI_FIRST = 4'h8;
    localparam logic [3:0] IDX_SP = 4'hd;
    localparam logic [3:0] IDX_LR = 4'he;
    localparam logic [3:0] IDX_PC = 4'hf;

    // Alignment masks for the stack pointer and program counter
    localparam logic [XLEN-1:0] SP_ALIGN = 32'hffff_fffc;
    localparam logic [XLEN-1:0] PC_ALIGN = 32'hffff_fffe;

    // Values after reset
    localparam logic [XLEN-1:0] GPR_RST = 32'h0000_0000;
    localparam logic [XLEN-1:0] SP_RST = 32'h0000_0000;
    localparam logic [XLEN-1:0] PC_RST = 32'h0000_0000;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [PRIO_W-1:0] PRIORITY_THRESHOLD_MASK_RST = 9'h000;

    typedef enum logic [1:0] {
        CMS_PRIV_THREAD,
        CMS_USER_THREAD,
        CMS_PRIV_HANDLER
    } cms_op_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [XLEN-1:0] wdata;
        logic wr;
        logic rd;
    } cms_bus_s;

    typedef struct packed {
        logic en;
        logic [3:0] idx;
        logic narrow;
        logic hi_ok;
        logic [XLEN-1:0] data;
    } cms_gwr_s;

    typedef struct packed {
        logic req;
        logic nmi;
        logic hard_fault;
        logic [PRIO_W-1:0] prio;
    } cms_irq_s;

    typedef struct packed {
        logic [NGPR-1:0][XLEN-1:0] gpr;
        logic [XLEN-1:0] lr;
        logic [XLEN-1:0] main_stack_pointer;
        logic [XLEN-1:0] process_stack_pointer;
        logic [XLEN-1:0] pc;
        logic [4:0] flags;
        logic [INTERRUPT_STATUS_VIEW_MSB:0] isv;
        logic [5:0] ici;
        logic [1:0] itb;
        logic primary_interrupt_mask;
        logic fault_level_mask;
        logic [PRIO_W-1:0] priority_threshold_mask;
        logic [1:0] mode;
        cms_op_e op;
        logic [XLEN-1:0] rdata;
        logic [XLEN-1:0] rd_a;
        logic [XLEN-1:0] rd_b;
        logic fault;
    } cms_state_s;
endpackage

// File: src/cms_core_regs.sv
// Core register set, status views, mask registers and operating mode
// What this block does
// RULE_01: Exactly three states: privileged handler, privileged thread, user thread.
// RULE_02: User level access to restricted things is blocked and faults.
// RULE_03: Handler mode while servicing an exception, thread mode otherwise.
// RULE_04: All sixteen core registers are 32 bits wide.
// RULE_05: Low eight registers always reachable; high five only by some forms.
// RULE_06: Stack pointer banked; process pointer only in thread mode.
// RULE_07: Stack pointer low two bits ignored and read as zero.
// RULE_08: A subroutine call writes the return address into the link.
// RULE_09: Program counter bit zero ignored and read as zero.
// RULE_10: Application view holds result flags in its top five bits.
// RULE_11: Interrupt view holds the active exception number in bits 8..0.
// RULE_12: Execution view holds continuable and if-then bits in two ranges.
// RULE_13: Compact set bit always reads one; clearing it faults.
// RULE_14: Status views readable and writable jointly and individually. Bus writes never reach the interrupt view.
// RULE_15: Primary mask lets only nonmaskable and hard fault through.
// RULE_16: Fault mask lets only the nonmaskable interrupt through.
// RULE_17: Priority threshold masks priority values at or above it; zero disables.
// RULE_18: Mode bit 0 picks privileged or user thread operation.
// RULE_19: Mode bit 1 picks the process stack in thread mode; zero in handler. User thread uses the process stack whatever bit 1 holds.
// RULE_20: Reset gives privileged thread, main stack, mode and masks cleared.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module cms_core_regs
    import cms_pkg::*;
(
    input wire logic clk_sys, // 40 MHz core clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic clk_en, // Freezes all state while low
    input wire cms_bus_s bus, // Register bus request
    output logic [XLEN-1:0] bus_rdata, // Read data, cycle after read
    input wire cms_gwr_s gwr, // Core register write
    input wire logic [3:0] rd_a_idx, // Read port A index
    input wire logic [3:0] rd_b_idx, // Read port B index
    output logic [XLEN-1:0] rd_a_data, // Read port A data, one cycle later
    output logic [XLEN-1:0] rd_b_data, // Read port B data, one cycle later
    input wire logic call_en, // Subroutine call executes
    input wire logic [XLEN-1:0] call_ret, // Return address of the call
    input wire logic pc_load, // Load the program counter
    input wire logic [XLEN-1:0] pc_next, // New program counter
    output logic [XLEN-1:0] pc_o, // Current program counter
    input wire logic flags_we, // Update result flags
    input wire logic [4:0] flags_in, // New result flags
    input wire logic restricted_op, // Restricted instruction or debug access
    input wire logic exc_enter, // Exception entry
    input wire logic [INTERRUPT_STATUS_VIEW_MSB:0] exc_num, // Exception number on entry
    input wire logic exc_return, // Exception return
    input wire cms_irq_s irq, // Candidate exception or interrupt
    output logic irq_accept, // Candidate passes the masks
    output cms_op_e op_state, // Current operating state
    output logic handler_mode, // Handler mode active
    output logic privileged, // Privileged level active
    output logic process_sp, // Process stack pointer selected
    output logic fault_o // Fault exception request, one cycle
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    cms_state_s s_q;
    cms_state_s s_d;
    logic is_user;
    logic psp_sel;
    logic [XLEN-1:0] sp_now;
    logic bus_blocked;

    // Reset release is synchronised; assertion stays asynchronous
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Combined status word; bit 24 is constant one
    function automatic logic [XLEN-1:0] psr_pack(input cms_state_s s);
        logic [XLEN-1:0] w;
        w = '0;
        w[APPLICATION_STATUS_VIEW_MSB:APPLICATION_STATUS_VIEW_LSB] = s.flags; // RULE_10
        w[INTERRUPT_STATUS_VIEW_MSB:0] = s.isv; // RULE_11
        w[ICI_MSB:ICI_LSB] = s.ici; // RULE_12
        w[IT_MSB:IT_LSB] = s.itb; // RULE_12
        w[TBIT_POS] = 1'b1; // RULE_13
        return w;
    endfunction

    // Registers that user level may neither read nor write
    function automatic logic priv_only(input logic [ADDR_W-1:0] a);
        return a == OFF_EXECUTION_STATUS_VIEW || a == OFF_PRIMARY_INTERRUPT_MASK || a == OFF_FAULT_LEVEL_MASK ||
            a == OFF_PRIORITY_THRESHOLD_MASK || a == OFF_MODE || a == OFF_MSP ||
            a == OFF_PSP;
    endfunction

    // High registers need an instruction form that can name them
    function automatic logic reachable(input logic [3:0] idx,
        input logic narrow, input logic hi_ok);
        if (idx < IDX_HI_FIRST) begin
            return 1'b1;
        end
        return !narrow || hi_ok;
    endfunction

    function automatic logic [XLEN-1:0] core_read(input cms_state_s s,
        input logic [3:0] idx, input logic [XLEN-1:0] sp);
        if (idx == IDX_SP) begin
            return sp & SP_ALIGN; // RULE_07
        end else if (idx == IDX_LR) begin
            return s.lr;
        end else if (idx == IDX_PC) begin
            return s.pc & PC_ALIGN; // RULE_09
        end
        return s.gpr[idx];
    endfunction

    assign is_user = s_q.op == CMS_USER_THREAD;
    // User thread always runs on the process stack; privileged thread may
    // opt in through the stack bit; handler never does
    assign psp_sel = s_q.op != CMS_PRIV_HANDLER &&
        (s_q.mode[MODE_USER_BIT] || s_q.mode[MODE_STACK_BIT]); // RULE_06
    assign sp_now = psp_sel ? s_q.process_stack_pointer : s_q.main_stack_pointer;
    assign bus_blocked = is_user && priv_only(bus.addr);

    always_comb begin
        s_d = s_q;
        s_d.fault = 1'b0;
        s_d.rdata = '0;

        if (gwr.en) begin
            if (!reachable(gwr.idx, gwr.narrow, gwr.hi_ok)) begin
                s_d.fault = 1'b1; // RULE_05
            end else if (gwr.idx == IDX_SP) begin
                if (psp_sel) begin
                    s_d.process_stack_pointer = gwr.data & SP_ALIGN; // RULE_07
                end else begin
                    s_d.main_stack_pointer = gwr.data & SP_ALIGN; // RULE_07
                end
            end else if (gwr.idx == IDX_LR) begin
                s_d.lr = gwr.data;
            end else if (gwr.idx == IDX_PC) begin
                s_d.pc = gwr.data & PC_ALIGN; // RULE_09
            end else begin
                s_d.gpr[gwr.idx] = gwr.data; // RULE_04
            end
        end
        if (call_en) begin
            s_d.lr = call_ret; // RULE_08
        end
        if (pc_load) begin
            s_d.pc = pc_next & PC_ALIGN; // RULE_09
        end
        if (flags_we) begin
            s_d.flags = flags_in; // RULE_10
        end
        if (restricted_op && is_user) begin
            s_d.fault = 1'b1; // RULE_02
        end

        // Software access; a bus write lands after the core's own updates
        if (bus.wr) begin
            if (bus_blocked) begin
                s_d.fault = 1'b1; // RULE_02
            end else begin
                unique case (bus.addr)
                    OFF_PSR: begin
                        s_d.flags = bus.wdata[APPLICATION_STATUS_VIEW_MSB:APPLICATION_STATUS_VIEW_LSB]; // RULE_14
                        if (!is_user) begin
                            s_d.ici = bus.wdata[ICI_MSB:ICI_LSB];
                            s_d.itb = bus.wdata[IT_MSB:IT_LSB];
                            if (!bus.wdata[TBIT_POS]) begin
                                s_d.fault = 1'b1; // RULE_13
                            end
                        end
                    end
                    OFF_APPLICATION_STATUS_VIEW: begin
                        s_d.flags = bus.wdata[APPLICATION_STATUS_VIEW_MSB:APPLICATION_STATUS_VIEW_LSB]; // RULE_14
                    end
                    OFF_EXECUTION_STATUS_VIEW: begin
                        s_d.ici = bus.wdata[ICI_MSB:ICI_LSB]; // RULE_14
                        s_d.itb = bus.wdata[IT_MSB:IT_LSB];
                        if (!bus.wdata[TBIT_POS]) begin
                            s_d.fault = 1'b1; // RULE_13
                        end
                    end
                    OFF_PRIMARY_INTERRUPT_MASK: begin
                        s_d.primary_interrupt_mask = bus.wdata[0];
                    end
                    OFF_FAULT_LEVEL_MASK: begin
                        s_d.fault_level_mask = bus.wdata[0];
                    end
                    OFF_PRIORITY_THRESHOLD_MASK: begin
                        s_d.priority_threshold_mask = bus.wdata[PRIO_W-1:0];
                    end
                    OFF_MODE: begin
                        s_d.mode[MODE_USER_BIT] = bus.wdata[MODE_USER_BIT];
                        // No alternate stack exists in handler mode
                        s_d.mode[MODE_STACK_BIT] =
                            bus.wdata[MODE_STACK_BIT] &&
                            s_q.op != CMS_PRIV_HANDLER; // RULE_19
                    end
                    OFF_MSP: begin
                        s_d.main_stack_pointer = bus.wdata & SP_ALIGN; // RULE_07
                    end
                    OFF_PSP: begin
                        s_d.process_stack_pointer = bus.wdata & SP_ALIGN; // RULE_07
                    end
                    default: begin
                        s_d.rdata = '0;
                    end
                endcase
            end
        end

        if (bus.rd && !bus_blocked) begin
            unique case (bus.addr)
                OFF_PSR: s_d.rdata = psr_pack(s_q); // RULE_14
                OFF_APPLICATION_STATUS_VIEW: begin
                    s_d.rdata[APPLICATION_STATUS_VIEW_MSB:APPLICATION_STATUS_VIEW_LSB] = s_q.flags; // RULE_10
                end
                OFF_INTERRUPT_STATUS_VIEW: s_d.rdata[INTERRUPT_STATUS_VIEW_MSB:0] = s_q.isv; // RULE_11
                OFF_EXECUTION_STATUS_VIEW: begin
                    s_d.rdata[ICI_MSB:ICI_LSB] = s_q.ici; // RULE_12
                    s_d.rdata[IT_MSB:IT_LSB] = s_q.itb;
                    s_d.rdata[TBIT_POS] = 1'b1; // RULE_13
                end
                OFF_PRIMARY_INTERRUPT_MASK: s_d.rdata[0] = s_q.primary_interrupt_mask;
                OFF_FAULT_LEVEL_MASK: s_d.rdata[0] = s_q.fault_level_mask;
                OFF_PRIORITY_THRESHOLD_MASK: s_d.rdata[PRIO_W-1:0] = s_q.priority_threshold_mask;
                OFF_MODE: s_d.rdata[1:0] = s_q.mode;
                OFF_MSP: s_d.rdata = s_q.main_stack_pointer & SP_ALIGN; // RULE_07
                OFF_PSP: s_d.rdata = s_q.process_stack_pointer & SP_ALIGN; // RULE_07
                OFF_OPSTATE: s_d.rdata[1:0] = s_q.op;
                default: s_d.rdata = '0;
            endcase
        end else if (bus.rd) begin
            s_d.fault = 1'b1; // RULE_02
        end

        // Exception entry outranks a same-cycle return
        if (exc_enter) begin
            s_d.op = CMS_PRIV_HANDLER; // RULE_03
            s_d.isv = exc_num; // RULE_11
            s_d.mode[MODE_STACK_BIT] = 1'b0; // RULE_19
        end else begin
            if (exc_return && s_q.op == CMS_PRIV_HANDLER) begin
                s_d.isv = '0;
                s_d.op = CMS_PRIV_THREAD; // RULE_03
            end
            if (s_d.op != CMS_PRIV_HANDLER) begin
                s_d.op = s_d.mode[MODE_USER_BIT] ?
                    CMS_USER_THREAD : CMS_PRIV_THREAD; // RULE_18
            end
        end

        s_d.rd_a = core_read(s_q, rd_a_idx, sp_now);
        s_d.rd_b = core_read(s_q, rd_b_idx, sp_now);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q.gpr <= {NGPR{GPR_RST}};
            s_q.lr <= GPR_RST;
            s_q.main_stack_pointer <= SP_RST;
            s_q.process_stack_pointer <= SP_RST;
            s_q.pc <= PC_RST;
            s_q.flags <= '0;
            s_q.isv <= '0;
            s_q.ici <= '0;
            s_q.itb <= '0;
            s_q.primary_interrupt_mask <= 1'b0; // RULE_20
            s_q.fault_level_mask <= 1'b0; // RULE_20
            s_q.priority_threshold_mask <= PRIORITY_THRESHOLD_MASK_RST; // RULE_20
            s_q.mode <= MODE_RST; // RULE_20
            s_q.op <= CMS_PRIV_THREAD; // RULE_20
            s_q.rdata <= '0;
            s_q.rd_a <= '0;
            s_q.rd_b <= '0;
            s_q.fault <= 1'b0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // Masking is purely combinational so the caller sees it at once
    always_comb begin
        irq_accept = 1'b0;
        if (irq.req) begin
            if (irq.nmi) begin
                irq_accept = 1'b1;
            end else if (s_q.fault_level_mask) begin
                irq_accept = 1'b0; // RULE_16
            end else if (irq.hard_fault) begin
                irq_accept = 1'b1; // RULE_15
            end else if (s_q.primary_interrupt_mask) begin
                irq_accept = 1'b0; // RULE_15
            end else begin
                irq_accept = s_q.priority_threshold_mask == '0 ||
                    irq.prio < s_q.priority_threshold_mask; // RULE_17
            end
        end
    end

    assign bus_rdata = s_q.rdata;
    assign rd_a_data = s_q.rd_a;
    assign rd_b_data = s_q.rd_b;
    assign pc_o = s_q.pc;
    assign op_state = s_q.op;
    assign handler_mode = s_q.op == CMS_PRIV_HANDLER; // RULE_01
    assign privileged = s_q.op != CMS_USER_THREAD; // RULE_01
    assign process_sp = psp_sel;
    assign fault_o = s_q.fault;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_enter;
        clk_en && exc_enter;
    endsequence
    sequence s_rd_psr;
        clk_en && bus.rd && bus.addr == OFF_PSR && !bus_blocked;
    endsequence
    sequence s_t_clear;
        clk_en && bus.wr && bus.addr == OFF_EXECUTION_STATUS_VIEW && !is_user &&
            !bus.wdata[TBIT_POS];
    endsequence

    chk_exc_entry: assert property ( // RULE_03
        s_enter |=> handler_mode && privileged &&
        s_q.isv == $past(exc_num))
        else $error("exception entry did not reach handler mode");
    chk_user_block: assert property ( // RULE_02
        clk_en && (bus.wr || bus.rd) && bus_blocked
        |=> fault_o && bus_rdata == '0)
        else $error("user access to privileged register not faulted");
    chk_sp_align: assert property ( // RULE_07
        clk_en && rd_a_idx == IDX_SP |=> rd_a_data[1:0] == 2'h0)
        else $error("stack pointer read not word aligned");
    chk_pc_align: assert property ( // RULE_09
        clk_en && rd_b_idx == IDX_PC |=> rd_b_data[0] == 1'b0)
        else $error("program counter read not halfword aligned");
    chk_call_link: assert property ( // RULE_08
        clk_en && call_en && !bus.wr |=> s_q.lr == $past(call_ret))
        else $error("call did not load the return address");
    // The set bit must survive a refused clear on a read in the following cycle as well
    chk_tbit_clear: assert property ( // RULE_13
        s_t_clear |=> (fault_o and
        (clk_en && bus.rd && bus.addr == OFF_EXECUTION_STATUS_VIEW && !bus_blocked
        |=> bus_rdata[TBIT_POS])))
        else $error("clearing the compact set bit not handled");
    chk_psr_read: assert property ( // RULE_14
        s_rd_psr |=> bus_rdata[TBIT_POS] &&
        bus_rdata[APPLICATION_STATUS_VIEW_MSB:APPLICATION_STATUS_VIEW_LSB] == $past(s_q.flags) &&
        bus_rdata[INTERRUPT_STATUS_VIEW_MSB:0] == $past(s_q.isv))
        else $error("combined status read wrong");
    chk_primary_interrupt_mask_gate: assert property ( // RULE_15
        irq.req && s_q.primary_interrupt_mask && !irq.nmi && !irq.hard_fault
        |-> !irq_accept)
        else $error("primary mask let an interrupt through");
    chk_fault_level_mask_gate: assert property ( // RULE_16
        irq.req && s_q.fault_level_mask |-> irq_accept == irq.nmi)
        else $error("fault mask gate wrong");
    chk_priority_threshold_mask_gate: assert property ( // RULE_17
        irq.req && !irq.nmi && !irq.hard_fault && !s_q.primary_interrupt_mask &&
        !s_q.fault_level_mask
        |-> irq_accept == (s_q.priority_threshold_mask == '0 || irq.prio < s_q.priority_threshold_mask))
        else $error("priority threshold gate wrong");
    chk_user_stack: assert property ( // RULE_06
        op_state == CMS_USER_THREAD |-> process_sp && !handler_mode)
        else $error("user thread not on process stack");
    chk_mode_state: assert property ( // RULE_18
        clk_en && bus.wr && bus.addr == OFF_MODE && !bus_blocked &&
        !exc_enter && !handler_mode
        |=> privileged == !$past(bus.wdata[MODE_USER_BIT]))
        else $error("thread privilege did not follow mode bit");
    chk_handler_stack: assert property ( // RULE_19
        handler_mode |-> !process_sp && !s_q.mode[MODE_STACK_BIT])
        else $error("handler mode on process stack");
endmodule // cms_core_regs

// File: bench/cms_core_partner.sv
// Exception logic model that hands entry and return pulses to the block
`timescale 1ns/10ps
module cms_core_partner
    import cms_pkg::*;
(
    input wire logic clk_sys, // Core clock
    input wire logic req, // Start an exception entry
    input wire logic ret, // Start an exception return
    input wire logic slow, // Add latency before entry
    input wire logic [INTERRUPT_STATUS_VIEW_MSB:0] num_in, // Number to report
    output logic exc_enter, // Entry pulse
    output logic [INTERRUPT_STATUS_VIEW_MSB:0] exc_num, // Number beside entry
    output logic exc_return // Return pulse
);
    logic [INTERRUPT_STATUS_VIEW_MSB:0] n;
    initial begin
        exc_enter = 1'b0;
        exc_return = 1'b0;
        exc_num = 9'h15a;
    end
    always begin
        @(posedge clk_sys);
        if (req) begin
            n = num_in;
            repeat (slow ? 3 : 0) @(posedge clk_sys);
            exc_num <= n;
            exc_enter <= 1'b1;
            @(posedge clk_sys);
            exc_enter <= 1'b0;
            // Number is only valid beside the pulse, so scramble it after
            exc_num <= ~n;
        end else if (ret) begin
            exc_return <= 1'b1;
            @(posedge clk_sys);
            exc_return <= 1'b0;
        end
    end
endmodule // cms_core_partner

// File: bench/cms_core_regs_tb_top.sv
// Self-checking bench for the core mode and special registers
`timescale 1ns/10ps
module cms_core_regs_tb_top;
import cms_pkg::*;
logic clk_sys = 0;
logic nrst = 0;
cms_bus_s bus = '0;
cms_gwr_s gwr = '0;
cms_irq_s irq = '0;
logic [3:0] rd_a_idx = 4'h0;
logic [3:0] rd_b_idx = 4'hf;
logic call_en = 0, pc_load = 0, flags_we = 0, restricted_op = 0;
logic clk_en = 1;
logic [XLEN-1:0] call_ret = '0, pc_next = '0, v, vm, vp;
logic [XLEN-1:0] bus_rdata, rd_a_data, rd_b_data, pc_o;
logic [4:0] flags_in = '0;
logic exc_enter, exc_return, irq_accept, handler_mode, privileged;
logic process_sp, fault_o;
logic [INTERRUPT_STATUS_VIEW_MSB:0] exc_num, x_num = '0;
cms_op_e op_state;
logic x_req = 0, x_ret = 0, x_slow = 0, rd_seen = 0;
logic [XLEN-1:0] exp_q[$];
logic [ADDR_W-1:0] offs [5] = '{OFF_PRIMARY_INTERRUPT_MASK, OFF_FAULT_LEVEL_MASK, OFF_PRIORITY_THRESHOLD_MASK,
    OFF_MODE, OFF_OPSTATE};
int n_mismatch = 0, checks_done = 0;
always #12.5 clk_sys = ~clk_sys;
cms_core_regs dut (.clk_sys, .nrst, .clk_en, .bus, .bus_rdata, .gwr,
    .rd_a_idx, .rd_b_idx, .rd_a_data, .rd_b_data, .call_en, .call_ret,
    .pc_load, .pc_next, .pc_o, .flags_we, .flags_in, .restricted_op,
    .exc_enter, .exc_num, .exc_return, .irq, .irq_accept, .op_state,
    .handler_mode, .privileged, .process_sp, .fault_o);
cms_core_partner ptr (.clk_sys, .req(x_req), .ret(x_ret), .slow(x_slow),
    .num_in(x_num), .exc_enter, .exc_num, .exc_return);
task check(input logic [XLEN-1:0] seen, input logic [XLEN-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
        n_mismatch++;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
task print_verdict;
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask
task wr(input logic [ADDR_W-1:0] a, input logic [XLEN-1:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
endtask
task rd(input logic [ADDR_W-1:0] a, input logic [XLEN-1:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
endtask
// Read data stands only in the cycle after the strobe
always @(posedge clk_sys) rd_seen <= bus.rd;
always @(negedge clk_sys) if (rd_seen) check(bus_rdata, exp_q.pop_front());
task fchk(input logic e);
    #1 check(fault_o, e);
endtask
task gw(input logic [3:0] i, input logic nw, input logic h,
        input logic [XLEN-1:0] d);
    @(posedge clk_sys);
    gwr <= '{en: 1'b1, idx: i, narrow: nw, hi_ok: h, data: d};
    @(posedge clk_sys);
    gwr.en <= 1'b0;
endtask
task rp(input logic [3:0] i, input logic [XLEN-1:0] e);
    @(posedge clk_sys);
    rd_a_idx <= i;
    @(posedge clk_sys);
    #1 check(rd_a_data, e);
endtask
task ig(input logic nm, input logic hf, input logic [PRIO_W-1:0] p,
        input logic e);
    @(posedge clk_sys);
    irq <= '{req: 1'b1, nmi: nm, hard_fault: hf, prio: p};
    #1 check(irq_accept, e);
endtask
task exc(input logic r, input logic s, input logic [8:0] nb, input logic h);
    @(posedge clk_sys);
    x_req <= ~r;
    x_ret <= r;
    x_slow <= s;
    x_num <= nb;
    @(posedge clk_sys);
    x_req <= 1'b0;
    x_ret <= 1'b0;
    for (int k = 0; k < 8 && handler_mode !== h; k++) @(posedge clk_sys);
    #1 check(handler_mode, h);
endtask
initial begin
    #100000;
    n_mismatch++;
    print_verdict;
end
initial begin
    void'($urandom(47));
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (offs[i]) rd(offs[i], 32'h0);
    rd(OFF_EXECUTION_STATUS_VIEW, 32'h0100_0000);
    rd(6'h3c, 32'h0);
    check(op_state, CMS_PRIV_THREAD);
    vm = $urandom;
    vp = $urandom;
    wr(OFF_MSP, vm);
    wr(OFF_PSP, vp);
    rd(OFF_MSP, vm & SP_ALIGN);
    rd(OFF_PSP, vp & SP_ALIGN);
    rp(IDX_SP, vm & SP_ALIGN);
    v = $urandom;
    @(posedge clk_sys);
    pc_load <= 1'b1;
    pc_next <= v;
    call_en <= 1'b1;
    call_ret <= ~v;
    @(posedge clk_sys);
    pc_load <= 1'b0;
    call_en <= 1'b0;
    #1 check(pc_o, v & PC_ALIGN);
    rp(IDX_LR, ~v);
    check(rd_b_data, v & PC_ALIGN);
    v = $urandom;
    gw(4'h3, 1'b1, 1'b0, v);
    fchk(1'b0);
    rp(4'h3, v);
    gw(4'h9, 1'b1, 1'b0, v);
    fchk(1'b1);
    rp(4'h9, 32'h0);
    gw(4'h9, 1'b0, 1'b0, v);
    rp(4'h9, v);
    @(posedge clk_sys);
    flags_we <= 1'b1;
    flags_in <= 5'h15;
    @(posedge clk_sys);
    flags_we <= 1'b0;
    rd(OFF_APPLICATION_STATUS_VIEW, 32'ha800_0000);
    wr(OFF_PSR, 32'h5600_fc00);
    fchk(1'b1);
    rd(OFF_PSR, 32'h5700_fc00);
    rd(OFF_EXECUTION_STATUS_VIEW, 32'h0700_fc00);
    wr(OFF_APPLICATION_STATUS_VIEW, 32'hf800_0000);
    rd(OFF_PSR, 32'hff00_fc00);
    ig(1'b0, 1'b0, 9'h004, 1'b1);
    wr(OFF_PRIORITY_THRESHOLD_MASK, 32'h4);
    ig(1'b0, 1'b0, 9'h003, 1'b1);
    ig(1'b0, 1'b0, 9'h004, 1'b0);
    wr(OFF_PRIORITY_THRESHOLD_MASK, 32'h0);
    wr(OFF_PRIMARY_INTERRUPT_MASK, 32'h1);
    ig(1'b0, 1'b0, 9'h001, 1'b0);
    ig(1'b0, 1'b1, 9'h001, 1'b1);
    wr(OFF_PRIMARY_INTERRUPT_MASK, 32'h0);
    wr(OFF_FAULT_LEVEL_MASK, 32'h1);
    ig(1'b0, 1'b1, 9'h001, 1'b0);
    ig(1'b1, 1'b0, 9'h001, 1'b1);
    wr(OFF_FAULT_LEVEL_MASK, 32'h0);
    wr(OFF_MODE, 32'h1);
    @(posedge clk_sys);
    #1 check(op_state, CMS_USER_THREAD);
    check(process_sp, 1'b1);
    check(privileged, 1'b0);
    rp(IDX_SP, vp & SP_ALIGN);
    rd(OFF_PRIMARY_INTERRUPT_MASK, 32'h0);
    fchk(1'b1);
    wr(OFF_MODE, 32'h0);
    fchk(1'b1);
    @(posedge clk_sys);
    restricted_op <= 1'b1;
    @(posedge clk_sys);
    restricted_op <= 1'b0;
    fchk(1'b1);
    wr(OFF_PSR, 32'h0100_0000);
    rd(OFF_PSR, 32'h0700_fc00);
    exc(1'b0, 1'b1, 9'h0a5, 1'b1);
    check(op_state, CMS_PRIV_HANDLER);
    check(process_sp, 1'b0);
    rd(OFF_INTERRUPT_STATUS_VIEW, 32'h0a5);
    rd(OFF_MODE, 32'h1);
    wr(OFF_MODE, 32'h0);
    exc(1'b1, 1'b0, 9'h0, 1'b0);
    check(op_state, CMS_PRIV_THREAD);
    rd(OFF_INTERRUPT_STATUS_VIEW, 32'h0);
    wr(OFF_MODE, 32'h2);
    @(posedge clk_sys);
    #1 check(process_sp, 1'b1);
    check(op_state, CMS_PRIV_THREAD);
    // A write while the enable is low must leave the threshold untouched
    clk_en <= 1'b0;
    wr(OFF_PRIORITY_THRESHOLD_MASK, 32'h7);
    clk_en <= 1'b1;
    rd(OFF_PRIORITY_THRESHOLD_MASK, 32'h0);
    repeat (3) @(posedge clk_sys);
    print_verdict;
end
endmodule // cms_core_regs_tb_top
